// ==== src/lcdft_pkg.sv ====
// package: register map, field layout and counts of the lcd frame timer
// Notes on behaviour
// - controller clock is source over 8, or over 16 with the tap bit set
// - tapped clock divided again by divisor code plus one, 1 to 8
// - frame lasts K prescaled ticks, K is 6 for third duty, else 8
// - low power waveform bit picks low power, otherwise standard waveform
// - waveform change reaches the pins only at the next frame start
// - duty code 00 quarter, 01 static, 10 half, 11 third
// - commons unused by the duty are driven to ground
// - pin count sets segment drivers; unused grounded, top 16 go to gpio
// - flag period is (frames field plus one) shifted by waveform bit
// - level field nonzero with the mask bit set enables the interrupt while the flag is set
// - hardware sets the done flag at a frame start, once per period
// - flag cleared on service or by writing one; zero writes ignored
// - blink on and off changes take effect at the next frame start
// - flash code selects 4, 2, 1 or 0.5 Hz
package lcdft_pkg;
    localparam int         ADR_W        = 5;
    localparam logic [2:0] IDX_CLKWAV   = 3'h1;
    localparam logic [2:0] IDX_SEGCNT   = 3'h2;
    localparam logic [2:0] IDX_IRQCTL   = 3'h3;
    localparam logic [2:0] IDX_FLAGS    = 3'h4;
    localparam logic [2:0] IDX_BLINK    = 3'h5;
    localparam logic [2:0] IDX_MASK     = 3'h6;
    localparam logic [7:0] RST_VAL      = 8'h00;
    localparam logic [7:0] CLKWAV_WMASK = 8'hfb;
    localparam logic [7:0] SEGCNT_WMASK = 8'h3f;
    localparam logic [7:0] IRQCTL_WMASK = 8'hfb;
    localparam logic [7:0] BLINK_WMASK  = 8'h0b;
    localparam logic [7:0] MASK_WMASK   = 8'h01;
    localparam int         TAP_BIT      = 7;
    localparam int         DIV_LSB      = 4;
    localparam int         LPW_BIT      = 3;
    localparam int         DUTY_LSB     = 0;
    localparam int         FRAMES_PER_INTERRUPT_LSB     = 3;
    localparam int         LVL_LSB      = 0;
    localparam int         BLINK_EN_BIT = 3;
    localparam int         RATE_LSB     = 0;
    localparam int         FLAG_BIT     = 0;
    localparam int         TAP_LO_DIV   = 8;
    localparam int         TAP_HI_DIV   = 16;
    localparam logic [2:0] TAP_LO_LAST  = 3'(TAP_LO_DIV - 1);
    localparam logic [3:0] TAP_HI_LAST  = 4'(TAP_HI_DIV - 1);
    localparam logic [2:0] K_STD_LAST   = 3'(8 - 1);
    localparam logic [2:0] K_THIRD_LAST = 3'(6 - 1);
    localparam int         SEG_PINS     = 40;
    localparam int         GPIO_PINS    = 16;
    localparam int         BLINK_FAST_HZ = 4;

    typedef enum logic [1:0] {
        DUTY_QUARTER = 2'h0,
        DUTY_STATIC  = 2'h1,
        DUTY_HALF    = 2'h2,
        DUTY_THIRD   = 2'h3
    } lcdft_duty_e;

    typedef enum logic [1:0] {
        FS_IDLE = 2'h0,
        FS_RUN  = 2'h1
    } lcdft_fs_e;

    // number of commons a duty setting uses
    function automatic logic [2:0] lcdft_commons(input lcdft_duty_e d);
        case (d)
            DUTY_STATIC: lcdft_commons = 3'h1;
            DUTY_HALF:   lcdft_commons = 3'h2;
            DUTY_THIRD:  lcdft_commons = 3'h3;
            default:     lcdft_commons = 3'h4;
        endcase
    endfunction
endpackage

// ==== src/lcdft_tick_if.sv ====
// interface: source and prescaled tick strobes between the timer modules
`timescale 1ns/100ps
`default_nettype none
interface lcdft_tick_if;
    logic src_tick;
    logic ps_tick;
    modport gen  (output src_tick, output ps_tick);
    modport sink (input src_tick, input ps_tick);
endinterface
`default_nettype wire

// ==== src/lcdft_clkgen.sv ====
// module: source clock synchroniser, ripple tap and frame clock divisor
`timescale 1ns/100ps
`default_nettype none
module lcdft_clkgen (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       lcd_src_clk,
    input  wire logic       tap_sel,
    input  wire logic [2:0] div_code,
    lcdft_tick_if.gen       tk
);
    import lcdft_pkg::*;
    logic [2:0] sync_reg, sync_next;
    logic       lvl_reg, lvl_next;
    logic [3:0] rip_reg, rip_next;
    logic [2:0] div_reg, div_next;
    logic       src_reg, src_next;
    logic       ps_reg, ps_next;

    always_comb begin
        sync_next = {sync_reg[1:0], lcd_src_clk};
        lvl_next  = lvl_reg;
        src_next  = 1'b0;
        rip_next  = rip_reg;
        div_next  = div_reg;
        ps_next   = 1'b0;
        // stages two and three agree: new level accepted
        if (sync_reg[2] == sync_reg[1] && sync_reg[2] != lvl_reg) begin
            lvl_next = sync_reg[2];
            src_next = sync_reg[2];
        end
        if (src_reg) begin
            rip_next = rip_reg + 4'h1;
            if (tap_sel ? (rip_reg == TAP_HI_LAST) : (rip_reg[2:0] == TAP_LO_LAST)) begin
                // >= so a smaller divisor written mid-count cannot strand it
                if (div_reg >= div_code) begin
                    div_next = 3'h0;
                    ps_next  = 1'b1;
                end else begin
                    div_next = div_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg <= 3'h0;
            lvl_reg  <= 1'b0;
            rip_reg  <= 4'h0;
            div_reg  <= 3'h0;
            src_reg  <= 1'b0;
            ps_reg   <= 1'b0;
        end else if (ce) begin
            sync_reg <= sync_next;
            lvl_reg  <= lvl_next;
            rip_reg  <= rip_next;
            div_reg  <= div_next;
            src_reg  <= src_next;
            ps_reg   <= ps_next;
        end
    end

    assign tk.src_tick = src_reg;
    assign tk.ps_tick  = ps_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_PS_AFTER_SRC: assert property (ps_reg && $past(ce) |-> $past(src_reg))
        else $error("prescaled tick without source tick");
    AST_TAP8_DIV1: assert property (ps_reg && $past(ce) && !$past(tap_sel)
                                    && $past(div_code) == 3'h0
                                    |-> $past(rip_reg[2:0]) == TAP_LO_LAST)
        else $error("divide-by-one tick off the tap");
endmodule
`default_nettype wire

// ==== src/lcdft_blink.sv ====
// module: blink enable latch and blink phase generator
`timescale 1ns/100ps
`default_nettype none
module lcdft_blink #(
    parameter int HALF_BASE = 4096
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    lcdft_tick_if.sink      tk,
    input  wire logic       frame_start,
    input  wire logic       blink_req,
    input  wire logic [1:0] rate,
    output logic            blink_on,
    output logic            blink_phase
);
    logic        on_reg, on_next;
    logic        ph_reg, ph_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] half_len;

    always_comb begin
        half_len = 16'(HALF_BASE) << rate;
        on_next  = frame_start ? blink_req : on_reg;
        ph_next  = ph_reg;
        cnt_next = cnt_reg;
        if (!on_reg) begin
            ph_next  = 1'b0;
            cnt_next = 16'h0000;
        end else if (tk.src_tick) begin
            if (cnt_reg >= half_len - 16'h0001) begin
                cnt_next = 16'h0000;
                ph_next  = !ph_reg;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            on_reg  <= 1'b0;
            ph_reg  <= 1'b0;
            cnt_reg <= 16'h0000;
        end else if (ce) begin
            on_reg  <= on_next;
            ph_reg  <= ph_next;
            cnt_reg <= cnt_next;
        end
    end

    assign blink_on    = on_reg;
    assign blink_phase = ph_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_BLINK_AT_FRAME: assert property ($changed(on_reg) |-> $past(frame_start))
        else $error("blink enable moved outside a frame start");
    AST_BLINK_OFF_IDLE: assert property (!on_reg && ce |=> !ph_reg)
        else $error("blink phase running while blink is off");
    COV_BLINK_TOGGLE: cover property (on_reg && $rose(ph_reg));
endmodule
`default_nettype wire

// ==== src/lcdft_top.sv ====
// module: lcd frame timing, pin control and wishbone register file
`timescale 1ns/100ps
`default_nettype none
module lcdft_top #(
    parameter int SRC_HZ = 32768
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          ce,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [lcdft_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic                          lcd_src_clk,
    input  wire logic                          irq_serviced,
    output logic                               irq_o,
    output logic      [1:0]                    irq_level_o,
    output logic                               frame_start_o,
    output logic      [3:0]                    com_select_o,
    output logic      [3:0]                    com_ground_o,
    output logic                               wave_low_power_o,
    output logic                               wave_polarity_o,
    output logic      [lcdft_pkg::SEG_PINS-1:0]  seg_drive_o,
    output logic      [lcdft_pkg::SEG_PINS-1:0]  seg_ground_o,
    output logic      [lcdft_pkg::GPIO_PINS-1:0] gpio_release_o,
    output logic                               blink_active_o,
    output logic                               blink_phase_o
);
    import lcdft_pkg::*;

    localparam int BLINK_HALF = SRC_HZ / (2 * BLINK_FAST_HZ);
    localparam int GPIO_BASE  = SEG_PINS - GPIO_PINS;

    lcdft_tick_if tk ();

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0]  clkwav_reg, clkwav_next;
    logic [7:0]  segcnt_reg, segcnt_next;
    logic [7:0]  irqctl_reg, irqctl_next;
    logic [7:0]  blink_reg, blink_next;
    logic [7:0]  mask_reg, mask_next;
    logic        ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [2:0]  idx;
    logic        req, wr;
    logic        flag_reg, flag_next;
    logic        set_evt;

    always_comb begin
        idx         = wb_adr_i[4:2];
        req         = wb_cyc_i && wb_stb_i;
        // write lands on the edge where the master sees ack
        wr          = req && wb_we_i && ack_reg && wb_sel_i[0];
        ack_next    = req && !ack_reg;
        rdat_next   = 32'h0000_0000;
        clkwav_next = clkwav_reg;
        segcnt_next = segcnt_reg;
        irqctl_next = irqctl_reg;
        blink_next  = blink_reg;
        mask_next   = mask_reg;
        if (req && !ack_reg && !wb_we_i) begin
            case (idx)
                IDX_CLKWAV: rdat_next[7:0] = clkwav_reg;
                IDX_SEGCNT: rdat_next[7:0] = segcnt_reg;
                IDX_IRQCTL: rdat_next[7:0] = irqctl_reg;
                IDX_FLAGS:  rdat_next[FLAG_BIT] = flag_reg;
                IDX_BLINK:  rdat_next[7:0] = blink_reg;
                IDX_MASK:   rdat_next[7:0] = mask_reg;
                default:    rdat_next = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            // reserved bits never stored, so they read zero
            case (idx)
                IDX_CLKWAV: clkwav_next = wb_dat_i[7:0] & CLKWAV_WMASK;
                IDX_SEGCNT: segcnt_next = wb_dat_i[7:0] & SEGCNT_WMASK;
                IDX_IRQCTL: irqctl_next = wb_dat_i[7:0] & IRQCTL_WMASK;
                IDX_BLINK:  blink_next  = wb_dat_i[7:0] & BLINK_WMASK;
                IDX_MASK:   mask_next   = wb_dat_i[7:0] & MASK_WMASK;
                default:    mask_next   = mask_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clkwav_reg <= RST_VAL;
            segcnt_reg <= RST_VAL;
            irqctl_reg <= RST_VAL;
            blink_reg  <= RST_VAL;
            mask_reg   <= RST_VAL;
            ack_reg    <= 1'b0;
            rdat_reg   <= 32'h0000_0000;
        end else if (ce) begin
            clkwav_reg <= clkwav_next;
            segcnt_reg <= segcnt_next;
            irqctl_reg <= irqctl_next;
            blink_reg  <= blink_next;
            mask_reg   <= mask_next;
            ack_reg    <= ack_next;
            rdat_reg   <= rdat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock generation and blink
    logic blink_on_w;
    logic blink_ph_w;
    logic fs_reg, fs_next;

    lcdft_clkgen u_clkgen (
        .clk         (clk),
        .srst        (srst),
        .ce          (ce),
        .lcd_src_clk (lcd_src_clk),
        .tap_sel     (clkwav_reg[TAP_BIT]),
        .div_code    (clkwav_reg[DIV_LSB +: 3]),
        .tk          (tk.gen)
    );

    lcdft_blink #(
        .HALF_BASE (BLINK_HALF)
    ) u_blink (
        .clk         (clk),
        .srst        (srst),
        .ce          (ce),
        .tk          (tk.sink),
        .frame_start (fs_reg),
        .blink_req   (blink_reg[BLINK_EN_BIT]),
        .rate        (blink_reg[RATE_LSB +: 2]),
        .blink_on    (blink_on_w),
        .blink_phase (blink_ph_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer
    lcdft_fs_e   st_reg, st_next;
    logic [2:0]  phase_reg, phase_next;
    logic        lpw_reg, lpw_next;
    lcdft_duty_e duty_reg, duty_next;
    logic        par_reg, par_next;
    logic [6:0]  fcnt_reg, fcnt_next;
    logic [6:0]  per_last;
    logic [2:0]  k_last;

    always_comb begin
        st_next    = st_reg;
        phase_next = phase_reg;
        fs_next    = 1'b0;
        lpw_next   = lpw_reg;
        duty_next  = duty_reg;
        par_next   = par_reg;
        fcnt_next  = fcnt_reg;
        set_evt    = 1'b0;
        k_last     = (duty_reg == DUTY_THIRD) ? K_THIRD_LAST : K_STD_LAST;
        per_last   = 7'(({2'b00, irqctl_reg[FRAMES_PER_INTERRUPT_LSB +: 5]} + 7'h01)
                        << clkwav_reg[LPW_BIT]) - 7'h01;
        case (st_reg)
            FS_IDLE: begin
                if (tk.ps_tick) begin
                    st_next    = FS_RUN;
                    phase_next = 3'h0;
                    fs_next    = 1'b1;
                end
            end
            FS_RUN: begin
                if (tk.ps_tick) begin
                    if (phase_reg >= k_last) begin
                        phase_next = 3'h0;
                        fs_next    = 1'b1;
                    end else begin
                        phase_next = phase_reg + 3'h1;
                    end
                end
            end
            default: st_next = FS_IDLE;
        endcase
        if (fs_next) begin
            lpw_next  = clkwav_reg[LPW_BIT];
            duty_next = lcdft_duty_e'(clkwav_reg[DUTY_LSB +: 2]);
            par_next  = !par_reg;
            if (fcnt_reg >= per_last) begin
                fcnt_next = 7'h00;
                set_evt   = 1'b1;
            end else begin
                fcnt_next = fcnt_reg + 7'h01;
            end
        end
        flag_next = flag_reg;
        if (irq_serviced || (wr && idx == IDX_FLAGS && wb_dat_i[FLAG_BIT])) begin
            flag_next = 1'b0;
        end
        // a frame event in the clearing cycle is kept
        if (set_evt) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg    <= FS_IDLE;
            phase_reg <= 3'h0;
            fs_reg    <= 1'b0;
            lpw_reg   <= 1'b0;
            duty_reg  <= DUTY_QUARTER;
            par_reg   <= 1'b0;
            fcnt_reg  <= 7'h00;
            flag_reg  <= 1'b0;
        end else if (ce) begin
            st_reg    <= st_next;
            phase_reg <= phase_next;
            fs_reg    <= fs_next;
            lpw_reg   <= lpw_next;
            duty_reg  <= duty_next;
            par_reg   <= par_next;
            fcnt_reg  <= fcnt_next;
            flag_reg  <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin control, all outputs registered
    logic [3:0]           comsel_reg, comsel_next;
    logic [3:0]           comgnd_reg, comgnd_next;
    logic                 pol_reg, pol_next;
    logic [SEG_PINS-1:0]  segdrv_reg, segdrv_next;
    logic [SEG_PINS-1:0]  seggnd_reg, seggnd_next;
    logic [GPIO_PINS-1:0] gpio_reg, gpio_next;
    logic                 irq_reg, irq_next;
    logic [2:0]           ncom;
    logic [1:0]           cidx;

    always_comb begin
        ncom = lcdft_commons(duty_reg);
        case (ncom)
            3'h1:    cidx = 2'h0;
            3'h2:    cidx = {1'b0, phase_reg[1]};
            default: cidx = phase_reg[2:1];
        endcase
        comsel_next = (st_reg == FS_RUN) ? (4'h1 << cidx) : 4'h0;
        for (int i = 0; i < 4; i++) begin
            comgnd_next[i] = (st_reg != FS_RUN) || (3'(i) >= ncom);
        end
        // low power waveform flips polarity per frame, so it needs two frames
        pol_next = lpw_reg ? par_reg : phase_reg[0];
        gpio_next = '0;
        for (int i = 0; i < SEG_PINS; i++) begin
            segdrv_next[i] = 6'(i) < segcnt_reg[5:0];
            seggnd_next[i] = !segdrv_next[i] && (i < GPIO_BASE);
        end
        for (int i = 0; i < GPIO_PINS; i++) begin
            gpio_next[i] = !segdrv_next[GPIO_BASE + i];
        end
        irq_next = flag_reg && mask_reg[FLAG_BIT] && (irqctl_reg[LVL_LSB +: 2] != 2'h0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            comsel_reg <= 4'h0;
            comgnd_reg <= 4'hf;
            pol_reg    <= 1'b0;
            segdrv_reg <= '0;
            seggnd_reg <= '0;
            gpio_reg   <= '0;
            irq_reg    <= 1'b0;
        end else if (ce) begin
            comsel_reg <= comsel_next;
            comgnd_reg <= comgnd_next;
            pol_reg    <= pol_next;
            segdrv_reg <= segdrv_next;
            seggnd_reg <= seggnd_next;
            gpio_reg   <= gpio_next;
            irq_reg    <= irq_next;
        end
    end

    assign wb_ack_o         = ack_reg;
    assign wb_dat_o         = rdat_reg;
    assign irq_o            = irq_reg;
    assign irq_level_o      = irqctl_reg[LVL_LSB +: 2];
    assign frame_start_o    = fs_reg;
    assign com_select_o     = comsel_reg;
    assign com_ground_o     = comgnd_reg;
    assign wave_low_power_o = lpw_reg;
    assign wave_polarity_o  = pol_reg;
    assign seg_drive_o      = segdrv_reg;
    assign seg_ground_o     = seggnd_reg;
    assign gpio_release_o   = gpio_reg;
    assign blink_active_o   = blink_on_w;
    assign blink_phase_o    = blink_ph_w;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_FRAME_LEN: assert property (fs_reg && $past(ce) && $past(st_reg) == FS_RUN
                                    |-> $past(phase_reg) == $past(k_last))
        else $error("frame did not span K prescaled ticks");
    AST_LPW_AT_FRAME: assert property ($changed(lpw_reg) |-> fs_reg)
        else $error("waveform changed outside a frame start");
    AST_FLAG_SET: assert property (set_evt && ce |=> flag_reg)
        else $error("frame event did not set the flag");
    AST_SERVICE_CLR: assert property (irq_serviced && !set_evt && ce |=> !flag_reg)
        else $error("service did not clear the flag");
    AST_COM_UNUSED: assert property (ce && st_reg == FS_RUN && duty_reg == DUTY_STATIC
                                     |=> comgnd_reg == 4'he)
        else $error("unused commons not grounded in static duty");
    AST_SEG_NONE: assert property (ce && segcnt_reg == 8'h00 |=> segdrv_reg == '0
                                   && gpio_reg == '1)
        else $error("segment drivers active with zero pin count");
    AST_IRQ_CAUSE: assert property (irq_o && $past(ce) |-> $past(flag_reg)
                                    && $past(irqctl_reg[LVL_LSB +: 2]) != 2'h0)
        else $error("interrupt without flag or level");
    // period of one frame: every frame strobe must have raised the flag event
    AST_PERIOD_ONE: assert property (fs_reg && $past(ce) && !$past(clkwav_reg[LPW_BIT])
                                     && $past(irqctl_reg[FRAMES_PER_INTERRUPT_LSB +: 5]) == 5'h00
                                     |-> $past(set_evt))
        else $error("frame strobe without flag event at period one");
    AST_ACK_PULSE: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    COV_FRAME: cover property (fs_reg && st_reg == FS_RUN);
    COV_FLAG_LPW: cover property (set_evt && lpw_reg);
    COV_SET_CLEAR: cover property (set_evt && irq_serviced);
endmodule
`default_nettype wire

// ==== tb/lcdft_glass.sv ====
// partner: glass panel model, source clock and common pin watch
`timescale 1ns/100ps
`default_nettype none
module lcdft_glass (
    input  wire logic       clk,
    input  wire logic [3:0] com_sel,
    input  wire logic [3:0] com_gnd,
    output logic            src_clk,
    output int              bad
);
    logic [2:0] cnt = 3'h0;
    initial src_clk = 1'b0;
    initial bad = 0;
    // slow source: 8 clk per half period, as the synchroniser needs
    always @(posedge clk) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) src_clk <= ~src_clk;
        if ((com_sel & com_gnd) != 4'h0) bad <= bad + 1;
    end
endmodule
`default_nettype wire

// ==== tb/lcdft_top_tb.sv ====
// testbench: register access, frame timing, pin and interrupt checks
`timescale 1ns/100ps
`default_nettype none
module lcdft_top_tb;
    import lcdft_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, svc = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] dw = 32'h0, dr, c;
    logic        ack, irq, fs, src, lp, pol, ba, bp, p;
    logic [1:0]  lvl;
    logic [3:0]  cs, cg;
    logic [39:0] sd, sg;
    logic [15:0] gp;
    logic [7:0]  q;
    int          n_fail = 0, samples_checked = 0, bad;
    logic [7:0]  cw [5] = '{8'h00, 8'h80, 8'h13, 8'h01, 8'h02};
    logic [31:0] ep [5] = '{32'd1024, 32'd2048, 32'd1536, 32'd1024, 32'd1024};
    logic [3:0]  eg [5] = '{4'h0, 4'h0, 4'h8, 4'he, 4'hc};
    lcdft_top #(.SRC_HZ(64)) DUT (.clk(clk), .srst(srst), .ce(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_ack_o(ack), .lcd_src_clk(src), .irq_serviced(svc), .irq_o(irq),
        .irq_level_o(lvl), .frame_start_o(fs), .com_select_o(cs), .com_ground_o(cg),
        .wave_low_power_o(lp), .wave_polarity_o(pol), .seg_drive_o(sd), .seg_ground_o(sg),
        .gpio_release_o(gp), .blink_active_o(ba), .blink_phase_o(bp));
    lcdft_glass P (.clk(clk), .com_sel(cs), .com_gnd(cg), .src_clk(src), .bad(bad));
    task automatic chk(input logic [39:0] e, input logic [39:0] s, input string n);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [2:0] i, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        dw <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // c ends as the spacing in clocks from the previous strobe
    task automatic wfs();
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (fs !== 1'b1);
    endtask
    task automatic complete_run();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial forever #10 clk = ~clk;
    // about three times the expected run
    initial begin
        #1800000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            wb(1'b1, IDX_CLKWAV, cw[r]);
            repeat (3) wfs();
            chk(ep[r], c, "frame spacing");
            chk(eg[r], cg, "common ground");
            $display("row %0d done", r);
        end
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(16'hffff, gp, "gpio after reset");
        for (int i = 1; i < 6; i++) begin
            wb(1'b0, 3'(i), 8'h00);
            chk(8'h00, q, "reset value");
        end
        $display("reset test done");
        wb(1'b1, IDX_SEGCNT, 8'h14);
        wb(1'b1, IDX_CLKWAV, 8'h08);
        chk(1'b0, lp, "waveform early");
        repeat (2) wfs();
        chk(1'b1, lp, "waveform");
        p = pol;
        wfs();
        chk(!p, pol, "low power polarity");
        chk(40'h00000fffff, sd, "segment drive");
        chk(40'h0000f00000, sg, "segment ground");
        $display("pin test done");
        wb(1'b1, IDX_MASK, 8'h01);
        wb(1'b1, IDX_IRQCTL, 8'h01);
        repeat (3) wfs();
        repeat (2) @(posedge clk);
        chk(1'b1, irq, "irq");
        chk(2'h1, lvl, "irq level");
        wb(1'b1, IDX_FLAGS, 8'h00);
        wb(1'b0, IDX_FLAGS, 8'h00);
        chk(8'h01, q, "flag kept");
        wb(1'b1, IDX_FLAGS, 8'h01);
        wb(1'b0, IDX_FLAGS, 8'h00);
        chk(8'h00, q, "flag cleared");
        chk(1'b0, irq, "irq cleared");
        repeat (2) wfs();
        @(posedge clk);
        chk(1'b1, irq, "irq before service");
        svc <= 1'b1;
        @(posedge clk);
        svc <= 1'b0;
        repeat (2) @(posedge clk);
        chk(1'b0, irq, "irq serviced");
        $display("irq test done");
        wb(1'b1, IDX_BLINK, 8'h08);
        chk(1'b0, ba, "blink early");
        wfs();
        @(posedge clk);
        chk(1'b1, ba, "blink on");
        // half period: 64/(2*4) source ticks of 16 clocks, doubled per rate code
        for (int r = 0; r < 4; r++) begin
            wb(1'b1, IDX_BLINK, 8'h08 | 8'(r));
            while (bp !== 1'b0)
                @(posedge clk);
            while (bp !== 1'b1)
                @(posedge clk);
            c = 0;
            do begin
                @(posedge clk);
                c++;
            end while (bp !== 1'b0);
            chk(32'd128 << r, c, "blink half period");
        end
        wb(1'b1, IDX_BLINK, 8'h00);
        wfs();
        @(posedge clk);
        chk(1'b0, ba, "blink off");
        $display("blink test done");
        wb(1'b1, IDX_CLKWAV, 8'hff);
        wb(1'b0, IDX_CLKWAV, 8'h00);
        chk(8'hfb, q, "reserved clock");
        wb(1'b1, IDX_BLINK, 8'hff);
        wb(1'b0, IDX_BLINK, 8'h00);
        chk(8'h0b, q, "reserved blink");
        wb(1'b0, 3'h7, 8'h00);
        chk(8'h00, q, "unmapped");
        chk(40'h0, 40'(bad), "glass commons");
        $display("reserved test done");
        complete_run();
    end
endmodule
`default_nettype wire
